// file: tb/terminal_operator.sv
//=========================================================================
// Purpose: Operator model: switches, pushbuttons and a pulse source.
// Assumes: A contact closed to common reads high; pins have pull-downs.
// Notes:   A released button reads low, so no stale level is kept.
//=========================================================================
`timescale 1ns/100ps
module terminal_operator (
	// Clock.
	input  wire logic i_clk,
	// Contacts to the terminal pins.
	output logic      o_first,
	output logic      o_second,
	output logic      o_third,
	output logic      o_up,
	output logic      o_down,
	output logic      o_pulse
);
	int period = 0;
	int pcnt   = 0;

	// All contacts start open; the pulse pin is set by its own process.
	initial begin
		{o_first, o_second, o_third, o_up, o_down} = 5'h00;
	end

	// The third contact is wired as the held enable, the first as run or
	// forward and the second as reverse or direction.
	task automatic put(input logic f, s, t, u, d);
		@(posedge i_clk);
		#1;
		{o_first, o_second, o_third, o_up, o_down} = {f, s, t, u, d};
	endtask : put

	// A momentary press of four cycles on the first or second button.
	task automatic press(input int pin);
		@(posedge i_clk);
		#1;
		if (pin == 0) o_first = 1'b1;
		else o_second = 1'b1;
		repeat (4) @(posedge i_clk);
		#1;
		if (pin == 0) o_first = 1'b0;
		else o_second = 1'b0;
	endtask : press

	// Square wave on the fifth terminal, period given in cycles.
	always @(posedge i_clk) begin
		pcnt    <= (pcnt + 1 >= period) ? 0 : pcnt + 1;
		o_pulse <= (pcnt < period / 2);
	end
endmodule : terminal_operator

// file: tb/testbench.sv
//=========================================================================
// Purpose: Self-checking bench for the terminal command block.
// Assumes: A tick of 20 cycles; units as in the package.
// Notes:   The operator model drives every terminal pin.
//=========================================================================
`timescale 1ns/100ps
module testbench;
	import terminal_command_pkg::*;
	localparam int TK = 20;
	logic               i_clk   = 1'b0;
	logic               i_reset = 1'b1;
	logic [1:0]         mode    = 2'h0;
	logic [1:0]         res     = RES_COARSE;
	logic [15:0]        rate    = 16'h03E8;
	logic [15:0]        fmax    = 16'h7FFF;
	logic [15:0]        smp [2];
	logic               cur [2];
	logic [15:0]        mn [3], mx [3], ft [3];
	logic signed [15:0] mns [3], mxs [3];
	logic               bz [3];
	logic               t1, t2, t3, tu, td, tp, forward_run, reverse_run;
	logic [15:0]        fref, prate;
	logic signed [15:0] s1, s2, sp;
	int                 error_cnt   = 0;
	int                 check_count = 0;

	// Block under test and the operator at its pins.
	terminal_command_scaler #(.TICK_CYCLES(TK)) u_terminal_command_scaler (
		.i_clk(i_clk), .i_reset(i_reset),
		.i_first_command_terminal(t1), .i_second_command_terminal(t2),
		.i_third_command_terminal(t3), .i_up_terminal(tu),
		.i_down_terminal(td), .i_fifth_digital_terminal(tp),
		.i_command_mode(mode), .i_freq_resolution(res),
		.i_updown_rate(rate), .i_max_freq(fmax),
		.i_analog_input_first(smp[0]), .i_first_current_mode(cur[0]),
		.i_first_min_in(mn[0]), .i_first_max_in(mx[0]),
		.i_first_min_set(mns[0]), .i_first_max_set(mxs[0]),
		.i_first_filter_time(ft[0]), .i_first_below_zero(bz[0]),
		.i_analog_input_second(smp[1]), .i_second_current_mode(cur[1]),
		.i_second_min_in(mn[1]), .i_second_max_in(mx[1]),
		.i_second_min_set(mns[1]), .i_second_max_set(mxs[1]),
		.i_second_filter_time(ft[1]), .i_second_below_zero(bz[1]),
		.i_pulse_min_in(mn[2]), .i_pulse_max_in(mx[2]),
		.i_pulse_min_set(mns[2]), .i_pulse_max_set(mxs[2]),
		.i_pulse_filter_time(ft[2]), .i_pulse_below_zero(bz[2]),
		.o_forward_run(forward_run), .o_reverse_run(reverse_run), .o_freq_ref(fref),
		.o_pulse_rate(prate), .o_first_setting(s1),
		.o_second_setting(s2), .o_pulse_setting(sp));
	terminal_operator u_terminal_operator (.i_clk(i_clk), .o_first(t1),
		.o_second(t2), .o_third(t3), .o_up(tu), .o_down(td), .o_pulse(tp));

	// Clock of 10 ns.
	always #5 i_clk = ~i_clk;

	// Helpers: settle, compare against a range, report.
	task automatic wcyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : wcyc
	task automatic chk(input string nm, input int lo, hi,
		input logic signed [16:0] got);
		check_count++;
		if ($isunknown(got) || got < lo || got > hi) begin
			error_cnt++;
			$display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask : chk
	task automatic run_is(input int e);
		chk("run", e, e, {15'h0000, forward_run, reverse_run});
	endtask : run_is
	task automatic final_report();
		if (error_cnt == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report

	// Expected curve result; a minimum above the maximum is clamped.
	function automatic int curve(int y, lo, hi, ls, hs, logic z);
		int m;
		m = (lo > hi) ? hi : lo;
		if (y >= hi) return hs;
		if (y < m) return z ? 0 : ls;
		return ls + (y - m) * (hs - ls) / (hi - m);
	endfunction : curve

	// Both two-wire schemes over all four switch combinations.
	task automatic t_two_wire(input logic [1:0] m);
		mode = m;
		for (int i = 0; i < 4; i++) begin
			u_terminal_operator.put(i[0], i[1], 1'b0, 1'b0, 1'b0);
			wcyc(5);
			if (m == MODE_TWO_WIRE_1) run_is(i == 1 ? 2 : i == 2 ? 1 : 0);
			else run_is(i == 1 ? 2 : i == 3 ? 1 : 0);
		end
	endtask : t_two_wire

	// Three-wire scheme 1: refused, latched, reversed, dropped.
	task automatic t_three_wire_1();
		mode = MODE_THREE_WIRE_1;
		u_terminal_operator.put(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		u_terminal_operator.press(0);
		wcyc(4);
		run_is(0);
		u_terminal_operator.put(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		wcyc(3);
		u_terminal_operator.press(0);
		wcyc(5);
		run_is(2);
		u_terminal_operator.press(1);
		wcyc(5);
		run_is(1);
		u_terminal_operator.put(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		wcyc(3);
		run_is(0);
		u_terminal_operator.put(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		wcyc(5);
		run_is(0);
	endtask : t_three_wire_1

	// Three-wire scheme 2: start press, live direction, drop.
	task automatic t_three_wire_2();
		mode = MODE_THREE_WIRE_2;
		u_terminal_operator.put(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		wcyc(3);
		u_terminal_operator.press(0);
		wcyc(5);
		run_is(2);
		u_terminal_operator.put(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
		wcyc(5);
		run_is(1);
		u_terminal_operator.put(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		wcyc(3);
		run_is(0);
	endtask : t_three_wire_2

	// Ramp with up or down held for a number of ticks.
	task automatic ramp(input logic u, d, input int n);
		u_terminal_operator.put(1'b0, 1'b0, 1'b0, u, d);
		wcyc(n * TK);
		u_terminal_operator.put(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		wcyc(4);
	endtask : ramp
	task automatic t_ramp();
		int base;
		ramp(1'b1, 1'b0, 10);
		chk("ramp coarse", 9, 11, {1'b0, fref});
		{rate, res} = {16'h07D0, RES_FINE};
		base = fref;
		ramp(1'b1, 1'b0, 10);
		chk("ramp fine", base + 18, base + 22, {1'b0, fref});
		fmax = 16'h0005;
		ramp(1'b1, 1'b0, 5);
		chk("ramp max", 5, 5, {1'b0, fref});
		ramp(1'b0, 1'b1, 10);
		chk("ramp zero", 0, 0, {1'b0, fref});
	endtask : t_ramp

	// Curve cases on both analog inputs with distinct settings.
	task automatic t_curves();
		int y;
		int e;
		int sv [6] = '{500, 1000, 50, 50, 1000, 920};
		{mx[0], mx[1], mxs[0], mxs[1]} = {16'h0384, 16'h0384, 16'h2710, 16'h1F40};
		{mns[0], mns[1]} = {16'sh03E8, -16'sh07D0};
		for (int k = 0; k < 6; k++) begin
			for (int c = 0; c < 2; c++) begin
				mn[c] = (k == 5) ? 16'h03B6 : 16'h0064;
				{smp[c], cur[c], bz[c]} = {sv[k][15:0], k == 4, k == 3};
			end
			wcyc(3 * TK);
			y = (k == 4) ? sv[k] / 2 : sv[k];
			for (int c = 0; c < 2; c++) begin
				e = curve(y, mn[c], mx[c], mns[c], mxs[c], bz[c]);
				chk("setting", e, e, c ? s2 : s1);
			end
		end
	endtask : t_curves

	// Step response through the smoothing filter.
	task automatic t_filter();
		{mn[0], mx[0], mns[0], mxs[0]} = {16'h0000, 16'h03E8, 16'h0000, 16'h2710};
		{cur[0], bz[0], ft[0], smp[0]} = {1'b0, 1'b0, 16'h0001, 16'h0000};
		wcyc(100 * TK);
		smp[0] = 16'h03E8;
		wcyc(5 * TK);
		chk("filtered", 2000, 6000, s1);
		wcyc(100 * TK);
		chk("settled", 9980, 10000, s1);
	endtask : t_filter

	// Pulse source of 40 cycles: 50 edges in each 100 ms gate.
	task automatic t_pulse();
		u_terminal_operator.period = 40;
		wcyc(250 * TK);
		chk("pulse rate", 49, 51, {1'b0, prate});
		chk("pulse setting", 98, 102, sp);
	endtask : t_pulse

	// Main sequence: defaults at time zero, reset, scenarios.
	initial begin
		for (int c = 0; c < 3; c++) begin
			{mn[c], mns[c], mxs[c]} = {16'h0000, 16'h0000, SET_MAX_DEFAULT};
			mx[c] = (c == 2) ? PULSE_MAX_DEFAULT : AI_MAX_DEFAULT;
			{ft[c], bz[c]} = {16'h0000, 1'b0};
		end
		smp = '{16'h0000, 16'h0000};
		cur = '{1'b0, 1'b0};
		wcyc(3);
		i_reset = 1'b0;
		wcyc(2);
		chk("reset ref", 0, 0, {1'b0, fref});
		t_two_wire(MODE_TWO_WIRE_1);
		t_two_wire(MODE_TWO_WIRE_2);
		t_three_wire_1();
		t_three_wire_2();
		t_ramp();
		t_curves();
		t_filter();
		t_pulse();
		final_report();
	end

	// Watchdog well beyond the expected run time.
	initial begin
		#300000;
		error_cnt++;
		final_report();
	end
endmodule : testbench

// file: verilog/analog_curve_channel.sv
//==============================================================================
// Purpose: One input channel: smoothing filter, then a two-point linear curve.
// Assumes: Sample already in the voltage or pulse-rate scale, updated on the same clock.
// Notes:   Filter steps once per millisecond tick.
//==============================================================================
`timescale 1ns/100ps
module analog_curve_channel
	import terminal_command_pkg::*;
(
	// Clock and reset.
	input  wire logic               i_clk,
	input  wire logic               i_reset,
	input  wire logic               i_tick,
	// Sample and curve settings.
	input  wire logic [15:0]        i_sample,
	input  wire logic [15:0]        i_min_in,
	input  wire logic [15:0]        i_max_in,
	input  wire logic signed [15:0] i_min_set,
	input  wire logic signed [15:0] i_max_set,
	input  wire logic [15:0]        i_filter_time,
	input  wire logic               i_below_zero,
	// Result.
	output logic signed [15:0]      o_setting
);
	import terminal_command_pkg::*;

	typedef struct packed {
		logic signed [31:0] acc;
		logic signed [15:0] setting;
	} chan_state_t;

	chan_state_t state_reg;
	chan_state_t state_next;
	logic [15:0] filtered;
	logic [15:0] low_in;

	assign filtered = state_reg.acc[FILT_FRAC +: VAL_W];
	// A minimum above the maximum is treated as the maximum.
	assign low_in = (i_min_in > i_max_in) ? i_max_in : i_min_in; // R18

	// =========================================================================
	// Filter and curve.
	always_comb begin
		int target;
		int span;
		int prod;
		int div;
		target = 0;
		span = 1;
		prod = 0;
		div = 1;
		state_next = state_reg;
		target = int'({8'h00, i_sample, 8'h00});
		div = int'(i_filter_time) * MS_PER_FILTER_UNIT;
		if (i_tick) begin
			if (i_filter_time == 16'h0000) begin
				state_next.acc = target; // R15
			end else begin
				state_next.acc = state_reg.acc
					+ (target - state_reg.acc) / div; // R15
			end
		end
		if (filtered >= i_max_in) begin
			state_next.setting = i_max_set; // R11
		end else if (filtered < low_in) begin
			state_next.setting = i_below_zero ? 16'sh0000 : i_min_set; // R12 R13
		end else begin
			span = int'(i_max_in) - int'(low_in);
			prod = (int'(filtered) - int'(low_in))
				* (int'(i_max_set) - int'(i_min_set));
			state_next.setting = 16'(int'(i_min_set) + prod / span); // R10
		end
	end

	// State register.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_setting = state_reg.setting;

	// =========================================================================
	// Checks.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	a_clamp_max: assert property (filtered >= i_max_in // R11
		|=> o_setting == $past(i_max_set))
		else $error("setting not clamped to maximum point");
	a_below_zero: assert property ( // R13
		(filtered < low_in) && i_below_zero |=> o_setting == 16'sh0000)
		else $error("below minimum did not give zero");
	a_below_min_set: assert property ( // R12
		(filtered < low_in) && !i_below_zero && (filtered < i_max_in)
		|=> o_setting == $past(i_min_set))
		else $error("below minimum did not give minimum setting");
	a_filter_bypass: assert property ( // R15
		i_tick && (i_filter_time == 16'h0000)
		|=> filtered == $past(i_sample))
		else $error("zero filter time did not pass sample");

endmodule : analog_curve_channel

// file: verilog/terminal_command_pkg.sv
//==============================================================================
// Purpose: Shared constants and types for the terminal command block.
// Assumes: 100 MHz system clock, fixed-point settings as listed below.
// Notes:   Voltages in 0.01 V, currents in 0.01 mA, pulse rate in 0.01 kHz,
//          settings in 0.01 percent, filter time in 0.01 s.
//==============================================================================
package terminal_command_pkg;

	// =========================================================================
	// Timing.
	localparam int CLK_PERIOD_NS      = 10;
	localparam int TICK_TIME_NS       = 1000000;
	localparam int TICK_CYCLES_DEF    = TICK_TIME_NS / CLK_PERIOD_NS;
	localparam int PULSE_GATE_MS      = 100;
	localparam int MS_PER_FILTER_UNIT = 10;
	localparam int MS_PER_SECOND      = 1000;

	// =========================================================================
	// Terminal command schemes and reference resolution codes.
	localparam logic [1:0] MODE_TWO_WIRE_1   = 2'h0;
	localparam logic [1:0] MODE_TWO_WIRE_2   = 2'h1;
	localparam logic [1:0] MODE_THREE_WIRE_1 = 2'h2;
	localparam logic [1:0] MODE_THREE_WIRE_2 = 2'h3;
	localparam logic [1:0] RES_COARSE        = 2'h1;
	localparam logic [1:0] RES_FINE          = 2'h2;

	// =========================================================================
	// Synchroniser bit positions for the digital terminals.
	localparam int PIN_FIRST  = 0;
	localparam int PIN_SECOND = 1;
	localparam int PIN_THIRD  = 2;
	localparam int PIN_UP     = 3;
	localparam int PIN_DOWN   = 4;
	localparam int PIN_PULSE  = 5;
	localparam int PIN_COUNT  = 6;

	// =========================================================================
	// Widths and defaults.
	localparam int CHANNELS  = 3;
	localparam int VAL_W     = 16;
	localparam int FILT_FRAC = 8;
	localparam logic [15:0] RATE_MIN          = 16'h0001;
	localparam logic [15:0] RATE_DEFAULT      = 16'h0064;
	localparam logic [15:0] AI_MAX_DEFAULT    = 16'h03E8;
	localparam logic [15:0] PULSE_MAX_DEFAULT = 16'h1388;
	localparam logic [15:0] SET_MAX_DEFAULT   = 16'h2710;
	localparam logic [15:0] FILTER_DEFAULT    = 16'h000A;

	// Run command held by the decoder.
	typedef enum logic [1:0] {CMD_STOP, CMD_FORWARD, CMD_REVERSE} cmd_t;

endpackage : terminal_command_pkg

// file: verilog/terminal_command_scaler.sv
//==============================================================================
// Purpose: Terminal run/direction decoder, up/down ramp and input scaling.
// Assumes: Terminals are raw pins; analog samples arrive on this clock.
// Notes:   Pins pass two flip-flops; run commands appear three cycles later.
//==============================================================================
// Contract
// [R1] Two-wire 1: first alone forward, second alone reverse, else stop.
// [R2] Two-wire 2: first enables run, second selects reverse when active.
// [R3] Three-wire 1: with third held, first press forward, second reverse.
// [R4] Three-wire schemes latch the last press command while enable stays on.
// [R5] Three-wire schemes stop at once when the third terminal drops.
// [R6] Three-wire 2: first press starts, second level picks direction.
// [R7] Configuration gives third terminal code 3, first 1, second 2.
// [R8] Up/down terminals ramp the frequency reference at the set rate.
// [R9] Rate range and units follow the reference resolution setting; the code ignores i_freq_resolution.
// [R10] First analog input maps linearly between its two curve points.
// [R11] Input above maximum point yields the maximum point setting.
// [R12] Input below minimum point uses the below-minimum option result.
// [R13] Below-minimum option 0 gives minimum setting, 1 gives zero.
// [R14] Current mode treats one milliampere as half a volt.
// [R15] Each analog input is smoothed by a configurable filter.
// [R16] Second analog input uses its own points, settings and filter.
// [R17] Pulse input on fifth terminal maps from 0 to 50 kHz, filtered.
// [R18] A minimum point above the maximum point is clamped to it.
`timescale 1ns/100ps
module terminal_command_scaler
	import terminal_command_pkg::*;
#(
	parameter int TICK_CYCLES = terminal_command_pkg::TICK_CYCLES_DEF
) (
	// Clock and reset.
	input  wire logic               i_clk,
	input  wire logic               i_reset,
	// Digital terminals (raw pins).
	input  wire logic               i_first_command_terminal,
	input  wire logic               i_second_command_terminal,
	input  wire logic               i_third_command_terminal,
	input  wire logic               i_up_terminal,
	input  wire logic               i_down_terminal,
	input  wire logic               i_fifth_digital_terminal,
	// Command and ramp configuration.
	input  wire logic [1:0]         i_command_mode,
	input  wire logic [1:0]         i_freq_resolution,
	input  wire logic [15:0]        i_updown_rate,
	input  wire logic [15:0]        i_max_freq,
	// First analog input and its curve.
	input  wire logic [15:0]        i_analog_input_first,
	input  wire logic               i_first_current_mode,
	input  wire logic [15:0]        i_first_min_in,
	input  wire logic [15:0]        i_first_max_in,
	input  wire logic signed [15:0] i_first_min_set,
	input  wire logic signed [15:0] i_first_max_set,
	input  wire logic [15:0]        i_first_filter_time,
	input  wire logic               i_first_below_zero,
	// Second analog input and its curve.
	input  wire logic [15:0]        i_analog_input_second,
	input  wire logic               i_second_current_mode,
	input  wire logic [15:0]        i_second_min_in,
	input  wire logic [15:0]        i_second_max_in,
	input  wire logic signed [15:0] i_second_min_set,
	input  wire logic signed [15:0] i_second_max_set,
	input  wire logic [15:0]        i_second_filter_time,
	input  wire logic               i_second_below_zero,
	// Pulse input curve.
	input  wire logic [15:0]        i_pulse_min_in,
	input  wire logic [15:0]        i_pulse_max_in,
	input  wire logic signed [15:0] i_pulse_min_set,
	input  wire logic signed [15:0] i_pulse_max_set,
	input  wire logic [15:0]        i_pulse_filter_time,
	input  wire logic               i_pulse_below_zero,
	// Results.
	output logic                    o_forward_run,
	output logic                    o_reverse_run,
	output logic [15:0]             o_freq_ref,
	output logic [15:0]             o_pulse_rate,
	output logic signed [15:0]      o_first_setting,
	output logic signed [15:0]      o_second_setting,
	output logic signed [15:0]      o_pulse_setting
);
	import terminal_command_pkg::*;

	typedef struct packed {
		logic [PIN_COUNT-1:0] sync_a;
		logic [PIN_COUNT-1:0] sync_b;
		logic [PIN_COUNT-1:0] prev;
		logic [1:0]           mode_prev;
		cmd_t                 cmd;
		logic                 forward_run;
		logic                 reverse_run;
		logic [16:0]          tick_cnt;
		logic [9:0]           frac;
		logic [15:0]          freq;
		logic [6:0]           gate_cnt;
		logic [15:0]          edge_cnt;
		logic [15:0]          pulse_rate;
	} top_state_t;

	top_state_t           state_reg;
	top_state_t           state_next;
	logic [PIN_COUNT-1:0] pins;
	logic [PIN_COUNT-1:0] rise;
	logic                 tick;
	logic                 t1;
	logic                 t2;
	logic                 t3;
	logic [15:0]          rate_eff;
	logic [16:0]          ramp_sum;
	logic [16:0]          carry;
	logic [15:0]          smp [CHANNELS];
	logic [15:0]          cmin [CHANNELS];
	logic [15:0]          cmax [CHANNELS];
	logic signed [15:0]   smin [CHANNELS];
	logic signed [15:0]   smax [CHANNELS];
	logic [15:0]          cfilt [CHANNELS];
	logic                 czero [CHANNELS];
	logic signed [15:0]   cset [CHANNELS];

	assign pins = {i_fifth_digital_terminal, i_down_terminal, i_up_terminal,
		i_third_command_terminal, i_second_command_terminal,
		i_first_command_terminal};
	// Edges are taken from the second stage only.
	assign rise = state_reg.sync_b & ~state_reg.prev;
	assign t1 = state_reg.sync_b[PIN_FIRST];
	assign t2 = state_reg.sync_b[PIN_SECOND];
	assign t3 = state_reg.sync_b[PIN_THIRD];
	assign tick = (state_reg.tick_cnt == 17'(TICK_CYCLES - 1));
	// Rate units ignore the resolution setting; zero is lifted to the least step.
	assign rate_eff = (i_updown_rate < RATE_MIN) ? RATE_MIN : i_updown_rate; // R9
	assign ramp_sum = 17'(state_reg.frac) + 17'(rate_eff); // R8
	assign carry = 17'(ramp_sum / 17'(MS_PER_SECOND));

	// =========================================================================
	// Command decode, ramp and pulse counting.
	always_comb begin
		state_next = state_reg;
		state_next.sync_a = pins;
		state_next.sync_b = state_reg.sync_a;
		state_next.prev = state_reg.sync_b;
		state_next.mode_prev = i_command_mode;
		state_next.tick_cnt = tick ? 17'h00000 : state_reg.tick_cnt + 17'h00001;
		case (i_command_mode)
			MODE_TWO_WIRE_1: begin
				if (t1 && !t2) begin
					state_next.cmd = CMD_FORWARD; // R1
				end else if (t2 && !t1) begin
					state_next.cmd = CMD_REVERSE; // R1
				end else begin
					state_next.cmd = CMD_STOP; // R1
				end
			end
			MODE_TWO_WIRE_2: begin
				if (!t1) begin
					state_next.cmd = CMD_STOP; // R2
				end else begin
					state_next.cmd = t2 ? CMD_REVERSE : CMD_FORWARD; // R2
				end
			end
			MODE_THREE_WIRE_1: begin
				// Third terminal is the held enable, presses are edges.
				if (!t3 || (state_reg.mode_prev != i_command_mode)) begin
					state_next.cmd = CMD_STOP; // R5 R7
				end else if (rise[PIN_FIRST]) begin
					state_next.cmd = CMD_FORWARD; // R3 R4
				end else if (rise[PIN_SECOND]) begin
					state_next.cmd = CMD_REVERSE; // R3 R4
				end
			end
			MODE_THREE_WIRE_2: begin
				if (!t3 || (state_reg.mode_prev != i_command_mode)) begin
					state_next.cmd = CMD_STOP; // R5 R7
				end else if (rise[PIN_FIRST] || state_reg.cmd != CMD_STOP) begin
					state_next.cmd = t2 ? CMD_REVERSE : CMD_FORWARD; // R6 R4
				end
			end
			default: begin
				state_next.cmd = CMD_STOP;
			end
		endcase
		state_next.forward_run = (state_next.cmd == CMD_FORWARD);
		state_next.reverse_run = (state_next.cmd == CMD_REVERSE);

		// Ramp: whole units per ms carried out of a per-mille fraction.
		if (state_reg.sync_b[PIN_UP] == state_reg.sync_b[PIN_DOWN]) begin
			state_next.frac = 10'h000;
		end else if (tick) begin
			state_next.frac = 10'(ramp_sum % 17'(MS_PER_SECOND)); // R8
			if (state_reg.sync_b[PIN_UP]) begin
				if (17'(state_reg.freq) + carry > 17'(i_max_freq)) begin
					state_next.freq = i_max_freq; // R8
				end else begin
					state_next.freq = 16'(17'(state_reg.freq) + carry); // R8
				end
			end else if (17'(state_reg.freq) > carry) begin
				state_next.freq = 16'(17'(state_reg.freq) - carry); // R8
			end else begin
				state_next.freq = 16'h0000;
			end
		end
		if (state_reg.freq > i_max_freq) begin
			state_next.freq = i_max_freq;
		end

		// Edges over a 100 ms gate give the rate in 10 Hz steps.
		if (rise[PIN_PULSE] && state_reg.edge_cnt != 16'hFFFF) begin
			state_next.edge_cnt = state_reg.edge_cnt + 16'h0001; // R17
		end
		if (tick) begin
			if (state_reg.gate_cnt == 7'(PULSE_GATE_MS - 1)) begin
				state_next.gate_cnt = 7'h00;
				state_next.pulse_rate = state_next.edge_cnt; // R17
				state_next.edge_cnt = 16'h0000;
			end else begin
				state_next.gate_cnt = state_reg.gate_cnt + 7'h01;
			end
		end
	end

	// State register.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// =========================================================================
	// Channel inputs: current mode halves the reading onto the volt scale.
	assign smp[0] = i_first_current_mode ? (i_analog_input_first >> 1) // R14
		: i_analog_input_first;
	assign smp[1] = i_second_current_mode ? (i_analog_input_second >> 1) // R14
		: i_analog_input_second;
	assign smp[2] = state_reg.pulse_rate; // R17
	assign cmin  = '{i_first_min_in, i_second_min_in, i_pulse_min_in};
	assign cmax  = '{i_first_max_in, i_second_max_in, i_pulse_max_in};
	assign smin  = '{i_first_min_set, i_second_min_set, i_pulse_min_set};
	assign smax  = '{i_first_max_set, i_second_max_set, i_pulse_max_set};
	assign cfilt = '{i_first_filter_time, i_second_filter_time,
		i_pulse_filter_time};
	assign czero = '{i_first_below_zero, i_second_below_zero,
		i_pulse_below_zero};

	// Each input has its own curve and filter.
	for (genvar g = 0; g < CHANNELS; g++) begin : g_chan // R16
		analog_curve_channel u_chan (
			.i_clk         (i_clk),
			.i_reset       (i_reset),
			.i_tick        (tick),
			.i_sample      (smp[g]),
			.i_min_in      (cmin[g]),
			.i_max_in      (cmax[g]),
			.i_min_set     (smin[g]),
			.i_max_set     (smax[g]),
			.i_filter_time (cfilt[g]),
			.i_below_zero  (czero[g]),
			.o_setting     (cset[g])
		);
	end

	// Outputs.
	assign o_forward_run    = state_reg.forward_run;
	assign o_reverse_run    = state_reg.reverse_run;
	assign o_freq_ref       = state_reg.freq;
	assign o_pulse_rate     = state_reg.pulse_rate;
	assign o_first_setting  = cset[0];
	assign o_second_setting = cset[1];
	assign o_pulse_setting  = cset[2];

	// =========================================================================
	// Checks.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	sequence s_fwd_press;
		(i_command_mode == MODE_THREE_WIRE_1) && t3 && rise[PIN_FIRST]
			&& $stable(i_command_mode);
	endsequence
	sequence s_latched_fwd;
		o_forward_run && (i_command_mode == MODE_THREE_WIRE_1);
	endsequence

	a_two_wire_fwd: assert property ( // R1
		(i_command_mode == MODE_TWO_WIRE_1) && t1 && !t2
		|=> o_forward_run && !o_reverse_run)
		else $error("two-wire forward not commanded");
	a_two_wire_stop: assert property ( // R1
		(i_command_mode == MODE_TWO_WIRE_1) && (t1 == t2)
		|=> !o_forward_run && !o_reverse_run)
		else $error("two-wire stop not commanded");
	a_enable_dir: assert property ( // R2
		(i_command_mode == MODE_TWO_WIRE_2) && t1
		|=> o_reverse_run == $past(t2) && o_forward_run == !$past(t2))
		else $error("two-wire enable direction wrong");
	a_three_stop: assert property ( // R5
		i_command_mode[1] && !t3 |=> !o_forward_run && !o_reverse_run)
		else $error("three-wire did not stop on enable loss");
	a_press_fwd: assert property (s_fwd_press |=> o_forward_run) // R3
		else $error("forward press not taken");
	a_latch_hold: assert property ( // R4
		s_latched_fwd ##1 (o_forward_run && t3 && !rise[PIN_SECOND]
			&& $stable(i_command_mode))
		|=> o_forward_run)
		else $error("latched run lost while enabled");
	a_sel_dir: assert property ( // R6
		(o_forward_run || o_reverse_run) && t3 && $stable(i_command_mode)
		&& (i_command_mode == MODE_THREE_WIRE_2)
		|=> o_reverse_run == $past(t2))
		else $error("selector did not steer direction");
	a_ramp_bound: assert property ( // R8
		$past(state_reg.freq) <= $past(i_max_freq) && $stable(i_max_freq)
		|-> o_freq_ref <= i_max_freq)
		else $error("reference ramped past the limit");
	a_ramp_hold: assert property ( // R8
		!tick && state_reg.freq <= i_max_freq |=> $stable(o_freq_ref))
		else $error("reference moved between ticks");

endmodule : terminal_command_scaler
